// ===== rtl/phrb_top.sv
// framer: delimiter and header registers, rx/tx rolling buffers
// Notes on behaviour
// - delimiter word in two writable byte registers
// - receive copies header bytes into header registers
// - transmit mirrors header from ring start
// - low header bit 7 is mode switch
// - low header bit 4 selects fcs length
// - crc generated and checked only for 16-bit
// - no crc pulse for 32-bit, frame end only
// - whitening bit 3, length high bits 2:0
// - high header byte holds length low bits
// - rx almost full at start plus offset
// - rx full at start plus length, then wrap
// - tx almost full when sending that offset
// - tx full at start plus length, then wrap
`timescale 1ns/1ns
`default_nettype none

module phrb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  // filling side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // draining side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } phrb_fifo_s;
  phrb_fifo_s     r_reg;
  phrb_fifo_s     r_next;
  logic [W-1:0]   store [D];
  logic           full;
  logic           push;
  logic           pop;

  // extra pointer bit tells full from empty
  assign full    = (r_reg.wp[AW] != r_reg.rp[AW]) &&
                   (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]);
  assign o_ready = !full;
  assign o_valid = r_reg.wp != r_reg.rp;
  assign o_data  = store[r_reg.rp[AW-1:0]];
  assign push    = i_valid && !full;
  assign pop     = o_valid && i_ready;

  // pointer update
  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
  end

  // storage carries no reset, pointers do
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
    if (push) begin
      store[r_reg.wp[AW-1:0]] <= i_data;
    end
  end
endmodule

module phrb_top (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  // serial register port, read data one cycle later
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [8:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  output logic [7:0]             o_reg_rdata,
  // mode and ring setup from the core
  input  wire logic              i_rx_mode,
  input  wire logic              i_tx_mode,
  input  wire logic [7:0]        i_rx_ring_start,
  input  wire logic [7:0]        i_tx_ring_start,
  input  wire logic [7:0]        i_tx_ring_length,
  // received byte stream from the demodulator
  input  wire logic              i_rx_sfd,
  input  wire logic              i_rx_valid,
  input  wire logic [7:0]        i_rx_data,
  output logic                   o_rx_ready,
  // transmit byte stream to the modulator
  input  wire logic              i_tx_start,
  output logic                   o_tx_valid,
  output logic [7:0]             o_tx_data,
  input  wire logic              i_tx_ready,
  // packet memory port
  output phrb_pkg::phrb_mem_s    o_mem,
  input  wire logic              i_mem_ready,
  input  wire logic [7:0]        i_mem_rdata,
  // status toward the core
  output logic [15:0]            o_sfd_word,
  output logic                   o_almost_full,
  output logic                   o_full,
  output logic                   o_rx_frame_end,
  output logic                   o_crc_ok,
  output logic                   o_tx_done
);
  import phrb_pkg::*;

  typedef struct packed {
    logic [7:0]  sfd_lo;
    logic [7:0]  sfd_hi;
    logic [7:0]  hdr_lo;
    logic [7:0]  hdr_hi;
    logic [7:0]  rx_sig;
    logic [7:0]  rx_len;
    logic [7:0]  tx_sig;
    logic [7:0]  rdata;
    logic        rx_act;
    logic [10:0] rx_idx;
    logic [15:0] rx_crc;
    logic [7:0]  rx_ofs;
    phrb_tx_e    tx_st;
    logic [10:0] tx_idx;
    logic [15:0] tx_crc;
    logic [7:0]  tx_ofs;
    logic [7:0]  tx_byte;
    phrb_mem_s   mem;
    logic        rd_pend;
    logic        af;
    logic        full;
    logic        eof;
    logic        crc_ok;
    logic        tx_done;
  } phrb_top_s;

  phrb_top_s   r_reg;
  phrb_top_s   r_next;
  logic        f_in_ready;
  logic        f_valid;
  logic [7:0]  f_data;
  logic        slot_free;
  logic        rx_take;
  logic        tx_take;
  logic        fcs16;
  logic [10:0] len;
  logic [10:0] rx_last;
  logic [10:0] tx_last;

  // one crc byte, lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] v;
    v = c;
    for (int i = 0; i < 8; i++) begin
      if (v[0] ^ b[i]) begin
        v = (v >> 1) ^ CRC_POLY;
      end else begin
        v = v >> 1;
      end
    end
    return v;
  endfunction

  // one ring step: event flags, then wrap to start after the last one
  function automatic phrb_step_s ring_step(input logic [7:0] ofs,
                                           input logic [7:0] sig,
                                           input logic [7:0] size);
    phrb_step_s s;
    s.af   = ofs == sig;
    s.full = ofs == size;
    s.ofs  = s.full ? RST_BYTE : 8'(ofs + 8'h01);
    return s;
  endfunction

  // the fifo decouples the demodulator from a stalling memory
  phrb_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_valid (rx_take),
    .i_data  (i_rx_data),
    .o_ready (f_in_ready),
    .o_valid (f_valid),
    .o_data  (f_data),
    .i_ready (slot_free)
  );

  // header decode shared by both directions
  assign fcs16      = r_reg.hdr_lo[HDR_FCS] == FCS_16;
  assign len        = {r_reg.hdr_lo[2:0], r_reg.hdr_hi};
  assign rx_last    = 11'(len + ONE_BYTE);
  assign tx_last    = fcs16 ? 11'(len - ONE_BYTE)
                            : 11'(len + ONE_BYTE);
  assign slot_free  = !r_reg.mem.en || i_mem_ready;
  assign rx_take    = r_reg.rx_act && i_rx_valid && f_in_ready;
  assign o_rx_ready = f_in_ready;
  assign o_tx_valid = r_reg.tx_st == T_SEND ||
                      r_reg.tx_st == T_CRC0 || r_reg.tx_st == T_CRC1;
  assign tx_take    = o_tx_valid && i_tx_ready;

  // next state of the whole block
  always_comb begin
    phrb_step_s  st;
    logic [15:0] cn;
    st = '0;
    cn = CRC_INIT;
    r_next = r_reg;
    r_next.af = 1'b0;
    r_next.full = 1'b0;
    r_next.eof = 1'b0;
    r_next.crc_ok = 1'b0;
    r_next.tx_done = 1'b0;
    // register writes; header registers ignore them
    if (i_reg_wr) begin
      case (i_reg_addr)
        A_SFD_LO: r_next.sfd_lo = i_reg_wdata;
        A_SFD_HI: r_next.sfd_hi = i_reg_wdata;
        A_RX_SIG: r_next.rx_sig = i_reg_wdata;
        A_RX_LEN: r_next.rx_len = i_reg_wdata;
        A_TX_SIG: r_next.tx_sig = i_reg_wdata;
        default: ;
      endcase
    end
    // register reads, unmapped reads as zero
    if (i_reg_rd) begin
      case (i_reg_addr)
        A_SFD_LO: r_next.rdata = r_reg.sfd_lo;
        A_SFD_HI: r_next.rdata = r_reg.sfd_hi;
        A_HDR_LO: r_next.rdata = r_reg.hdr_lo;
        A_HDR_HI: r_next.rdata = r_reg.hdr_hi;
        A_RX_SIG: r_next.rdata = r_reg.rx_sig;
        A_RX_LEN: r_next.rdata = r_reg.rx_len;
        A_TX_SIG: r_next.rdata = r_reg.tx_sig;
        default:  r_next.rdata = RST_BYTE;
      endcase
    end
    // receive: two header bytes, then payload and fcs
    if (rx_take) begin
      if (r_reg.rx_idx == 11'h000) begin
        r_next.hdr_lo = i_rx_data & HDR_MASK;
      end else if (r_reg.rx_idx == ONE_BYTE) begin
        r_next.hdr_hi = i_rx_data;
      end else begin
        r_next.rx_crc = crc_step(r_reg.rx_crc, i_rx_data);
        if (r_reg.rx_idx == rx_last) begin
          r_next.rx_act = 1'b0;
          r_next.eof = 1'b1;
          // zero residual means good; never for the long fcs
          r_next.crc_ok = fcs16 && r_next.rx_crc == CRC_INIT;
        end
      end
      r_next.rx_idx = 11'(r_reg.rx_idx + ONE_BYTE);
    end
    // memory slot: buffered rx writes first, then tx reads
    r_next.rd_pend = r_reg.mem.en && !r_reg.mem.we && i_mem_ready;
    if (slot_free) begin
      r_next.mem.en = 1'b0;
      if (f_valid) begin
        st = ring_step(r_reg.rx_ofs, r_reg.rx_sig, r_reg.rx_len);
        r_next.mem = '{en: 1'b1, we: 1'b1,
                       addr: 8'(i_rx_ring_start + r_reg.rx_ofs),
                       wdata: f_data};
        r_next.af = st.af;
        r_next.full = st.full;
        r_next.rx_ofs = st.ofs;
      end else if (r_reg.tx_st == T_RD) begin
        r_next.mem = '{en: 1'b1, we: 1'b0,
                       addr: 8'(i_tx_ring_start + r_reg.tx_ofs),
                       wdata: RST_BYTE};
        r_next.tx_st = T_WAIT;
      end
    end
    // a new frame restarts the receive ring at its start
    if (i_rx_sfd && i_rx_mode) begin
      r_next.rx_act = 1'b1;
      r_next.rx_idx = 11'h000;
      r_next.rx_crc = CRC_INIT;
      r_next.rx_ofs = RST_BYTE;
    end
    // transmit sequencer
    case (r_reg.tx_st)
      T_IDLE: begin
        if (i_tx_start && i_tx_mode) begin
          r_next.tx_st = T_RD;
          r_next.tx_idx = 11'h000;
          r_next.tx_ofs = RST_BYTE;
          r_next.tx_crc = CRC_INIT;
        end
      end
      T_RD: ;
      T_WAIT: begin
        if (r_reg.rd_pend) begin
          r_next.tx_byte = i_mem_rdata;
          r_next.tx_st = T_SEND;
          if (r_reg.tx_idx == 11'h000) begin
            r_next.hdr_lo = i_mem_rdata & HDR_MASK;
          end else if (r_reg.tx_idx == ONE_BYTE) begin
            r_next.hdr_hi = i_mem_rdata;
          end
        end
      end
      T_SEND: begin
        if (tx_take) begin
          st = ring_step(r_reg.tx_ofs, r_reg.tx_sig, i_tx_ring_length);
          r_next.af = r_next.af | st.af;
          r_next.full = r_next.full | st.full;
          r_next.tx_ofs = st.ofs;
          cn = r_reg.tx_crc;
          if (r_reg.tx_idx >= HDR_BYTES) begin
            cn = crc_step(r_reg.tx_crc, r_reg.tx_byte);
          end
          r_next.tx_crc = cn;
          r_next.tx_idx = 11'(r_reg.tx_idx + ONE_BYTE);
          if (r_reg.tx_idx != tx_last) begin
            r_next.tx_st = T_RD;
          end else if (fcs16) begin
            r_next.tx_st = T_CRC0;
            r_next.tx_byte = cn[7:0];
          end else begin
            r_next.tx_st = T_IDLE;
            r_next.tx_done = 1'b1;
          end
        end
      end
      T_CRC0: begin
        if (tx_take) begin
          r_next.tx_byte = r_reg.tx_crc[15:8];
          r_next.tx_st = T_CRC1;
        end
      end
      T_CRC1: begin
        if (tx_take) begin
          r_next.tx_st = T_IDLE;
          r_next.tx_done = 1'b1;
        end
      end
      default: r_next.tx_st = T_IDLE;
    endcase
  end

  // single state register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_reg_rdata    = r_reg.rdata;
  assign o_tx_data      = r_reg.tx_byte;
  assign o_mem          = r_reg.mem;
  assign o_sfd_word     = {r_reg.sfd_hi, r_reg.sfd_lo};
  assign o_almost_full  = r_reg.af;
  assign o_full         = r_reg.full;
  assign o_rx_frame_end = r_reg.eof;
  assign o_crc_ok       = r_reg.crc_ok;
  assign o_tx_done      = r_reg.tx_done;

  // checks on the block's outputs and its internal state registers
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_rx_fill;
    slot_free && f_valid;
  endsequence
  sequence s_tx_send;
    r_reg.tx_st == T_SEND && i_tx_ready;
  endsequence

  chk_sfd_write: assert property (
    i_reg_wr && i_reg_addr == A_SFD_HI |=>
      o_sfd_word[15:8] == $past(i_reg_wdata))
    else $error("delimiter high byte not written");
  chk_hdr_capture: assert property (
    rx_take && r_reg.rx_idx == 11'h000 && !i_rx_sfd |=>
      r_reg.hdr_lo == ($past(i_rx_data) & HDR_MASK))
    else $error("header low byte not captured");
  chk_hdr_reserved: assert property (
    (r_reg.hdr_lo & ~HDR_MASK) == RST_BYTE)
    else $error("reserved header bits set");
  chk_crc_only16: assert property (
    o_crc_ok |-> o_rx_frame_end && r_reg.hdr_lo[HDR_FCS])
    else $error("crc pulse without short fcs");
  chk_rx_almost: assert property (
    s_rx_fill ##0 r_reg.rx_ofs == r_reg.rx_sig |=> o_almost_full)
    else $error("rx almost full missing");
  chk_rx_wrap: assert property (
    s_rx_fill ##0 r_reg.rx_ofs == r_reg.rx_len |=>
      o_full && r_reg.rx_ofs == RST_BYTE)
    else $error("rx ring did not wrap");
  chk_tx_mirror: assert property (
    r_reg.tx_st == T_WAIT && r_reg.rd_pend &&
      r_reg.tx_idx == ONE_BYTE |=> r_reg.hdr_hi == $past(i_mem_rdata))
    else $error("tx header not mirrored");
  chk_tx_fcs16: assert property (
    r_reg.tx_st == T_CRC0 |-> fcs16 ##1 o_tx_valid)
    else $error("crc bytes sent for long fcs");
  chk_tx_almost: assert property (
    s_tx_send ##0 r_reg.tx_ofs == r_reg.tx_sig |=> o_almost_full)
    else $error("tx almost full missing");
  chk_tx_wrap: assert property (
    s_tx_send ##0 r_reg.tx_ofs == i_tx_ring_length |=>
      o_full ##0 r_reg.tx_ofs == RST_BYTE)
    else $error("tx ring did not wrap");
endmodule

`default_nettype wire

// ===== inc/phrb_pkg.sv
// package: register map, header fields and shared types of the framer
package phrb_pkg;
  // register addresses on the serial register port
  localparam int          ADDR_W   = 9;
  localparam logic [8:0]  A_SFD_LO = 9'h130;
  localparam logic [8:0]  A_SFD_HI = 9'h131;
  localparam logic [8:0]  A_HDR_LO = 9'h132;
  localparam logic [8:0]  A_HDR_HI = 9'h133;
  localparam logic [8:0]  A_RX_SIG = 9'h134;
  localparam logic [8:0]  A_RX_LEN = 9'h135;
  localparam logic [8:0]  A_TX_SIG = 9'h136;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  // header low byte fields
  localparam int          HDR_MS   = 7;
  localparam int          HDR_FCS  = 4;
  localparam int          HDR_WH   = 3;
  localparam logic [7:0]  HDR_MASK = 8'h9f;
  localparam logic        FCS_16   = 1'b1;
  localparam logic [10:0] HDR_BYTES = 11'h002;
  localparam logic [10:0] ONE_BYTE  = 11'h001;
  // reflected ccitt polynomial, zero residual on a good frame
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam int          FIFO_W   = 8;
  localparam int          FIFO_D   = 8;
  // packet memory request
  typedef struct packed {
    logic       en;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } phrb_mem_s;
  // result of one ring pointer step
  typedef struct packed {
    logic       af;
    logic       full;
    logic [7:0] ofs;
  } phrb_step_s;
  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_RD   = 3'b001,
    T_WAIT = 3'b010,
    T_SEND = 3'b011,
    T_CRC0 = 3'b100,
    T_CRC1 = 3'b101
  } phrb_tx_e;
endpackage

// ===== sim/phrb_mem_model.sv
// packet memory model: stalls on request, read data one cycle after accept
`timescale 1ns/1ns
`default_nettype none
module phrb_mem_model (
  // clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_rst,
  // request side
  input  wire phrb_pkg::phrb_mem_s i_mem,
  input  wire logic                i_slow,
  output logic                     o_ready,
  output logic [7:0]               o_rdata
);
  import phrb_pkg::*;
  logic [7:0] mem [0:255];
  logic       tick_reg;
  // slow mode accepts every other cycle so the rx fifo backs up
  assign o_ready = !i_slow || tick_reg;
  // read data stands one cycle, then the bus shows a changing pattern
  always @(posedge i_clock) begin
    tick_reg <= i_rst ? 1'b0 : !tick_reg;
    o_rdata  <= i_rst ? 8'h00 : ~o_rdata;
    if (!i_rst && i_mem.en && o_ready) begin
      if (i_mem.we) begin
        mem[i_mem.addr] <= i_mem.wdata;
      end else begin
        o_rdata <= mem[i_mem.addr];
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/phrb_top_bench.sv
// self-checking bench: registers, rx ring fill, tx ring send
`timescale 1ns/1ns
`default_nettype none
module phrb_top_bench;
  import phrb_pkg::*;
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } phrb_row_s;
  localparam int RX_SIG = 5;
  localparam int RX_LEN = 9;
  localparam int TX_SIG = 4;
  localparam int TX_LEN = 5;
  logic        i_clock, i_rst, i_reg_wr, i_reg_rd, i_rx_mode, i_tx_mode;
  logic        i_rx_sfd, i_rx_valid, i_tx_start, i_tx_ready, i_slow;
  logic [8:0]  i_reg_addr;
  logic [7:0]  i_reg_wdata, i_rx_data, o_reg_rdata, o_tx_data, mem_rdata;
  logic        o_rx_ready, o_tx_valid, o_almost_full, o_full;
  logic        o_rx_frame_end, o_crc_ok, o_tx_done, mem_ready;
  logic [15:0] o_sfd_word;
  phrb_mem_s   o_mem;
  logic [7:0]  txq [$];
  int          err_total, checked, af_n, full_n, end_n, ok_n, done_n, stalls;
  phrb_row_s   rows [8];

  phrb_top DUT (
    .i_clock(i_clock), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_rx_mode(i_rx_mode), .i_tx_mode(i_tx_mode),
    .i_rx_ring_start(8'h80), .i_tx_ring_start(8'h40),
    .i_tx_ring_length(8'(TX_LEN)), .i_rx_sfd(i_rx_sfd),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready),
    .i_tx_start(i_tx_start), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
    .i_tx_ready(i_tx_ready), .o_mem(o_mem), .i_mem_ready(mem_ready),
    .i_mem_rdata(mem_rdata), .o_sfd_word(o_sfd_word),
    .o_almost_full(o_almost_full), .o_full(o_full),
    .o_rx_frame_end(o_rx_frame_end), .o_crc_ok(o_crc_ok),
    .o_tx_done(o_tx_done)
  );
  phrb_mem_model MEM (
    .i_clock(i_clock), .i_rst(i_rst), .i_mem(o_mem), .i_slow(i_slow),
    .o_ready(mem_ready), .o_rdata(mem_rdata)
  );

  // clock
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // modulator side stalls every other cycle
  always @(posedge i_clock) begin
    i_tx_ready <= !i_tx_ready;
  end
  // sampled mid-cycle, where strobes and pulses are settled
  always @(negedge i_clock) begin
    if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) txq.push_back(o_tx_data);
    if (o_almost_full !== 1'b0) af_n++;
    if (o_full !== 1'b0) full_n++;
    if (o_rx_frame_end !== 1'b0) end_n++;
    if (o_crc_ok !== 1'b0) ok_n++;
    if (o_tx_done !== 1'b0) done_n++;
  end

  task automatic complete_run();
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fail_wait();
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    complete_run();
  endtask
  // one register access; read data is settled after the next edge
  task automatic reg_io(input logic wr, input logic [8:0] a,
                        input logic [7:0] d);
    @(posedge i_clock);
    i_reg_wr    <= wr;
    i_reg_rd    <= !wr;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
    #1;
  endtask
  // reflected crc, low byte sent first gives a zero residual
  function automatic logic [15:0] crc16(input logic [7:0] q [$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int j = 0; j < 8; j++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction
  // byte held until the fifo shows ready before an edge
  task automatic rx_byte(input logic [7:0] d);
    logic ok;
    int   n;
    i_rx_valid <= 1'b1;
    i_rx_data  <= d;
    n = 0;
    do begin
      @(negedge i_clock);
      ok = o_rx_ready;
      stalls += (ok !== 1'b1);
      @(posedge i_clock);
      n++;
    end while (ok !== 1'b1 && n < 200);
    if (ok !== 1'b1) fail_wait();
  endtask
  task automatic wait_idle();
    int q;
    int n;
    q = 0;
    n = 0;
    while (q < 6 && n < 300) begin
      @(negedge i_clock);
      q = (o_mem.en === 1'b0) ? q + 1 : 0;
      n++;
    end
    if (q < 6) fail_wait();
  endtask
  // one received frame; ring expectations follow the offset walk
  task automatic rx_frame(input logic [7:0] h0, input logic [7:0] h1,
                          input logic bad);
    logic [7:0]  b [$];
    logic [7:0]  em [0:RX_LEN];
    logic [15:0] c;
    int          o, af_e, fu_e;
    b = {h0, h1};
    for (int k = 0; k < {h0[2:0], h1} - (h0[HDR_FCS] ? 2 : 0); k++) begin
      b.push_back(8'(k * 7 + 3));
    end
    if (h0[HDR_FCS] == FCS_16) begin
      c = crc16(b[2:$]) ^ {15'h0000, bad};
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
    end
    o = 0;
    af_e = 0;
    fu_e = 0;
    foreach (b[i]) begin
      em[o] = b[i];
      af_e += (o == RX_SIG);
      fu_e += (o == RX_LEN);
      o = (o == RX_LEN) ? 0 : o + 1;
    end
    af_n = 0;
    full_n = 0;
    end_n = 0;
    ok_n = 0;
    stalls = 0;
    @(posedge i_clock);
    i_rx_sfd <= 1'b1;
    @(posedge i_clock);
    i_rx_sfd <= 1'b0;
    foreach (b[i]) rx_byte(b[i]);
    i_rx_valid <= 1'b0;
    wait_idle();
    check(end_n, 1);
    check(ok_n, h0[HDR_FCS] && !bad);
    check(af_n, af_e);
    check(full_n, fu_e);
    for (int k = 0; k <= RX_LEN; k++) begin
      check(MEM.mem[8'h80 + k], em[k]);
    end
    reg_io(1'b0, A_HDR_LO, 8'h00);
    check(o_reg_rdata, h0 & HDR_MASK);
    reg_io(1'b0, A_HDR_HI, 8'h00);
    check(o_reg_rdata, h1);
  endtask
  // one transmission of a length 8 frame from the tx ring
  task automatic tx_run(input logic [7:0] h0);
    logic [7:0]  e [$];
    logic [15:0] c;
    int          o, n, af_e, fu_e;
    MEM.mem[8'h40] = h0;
    MEM.mem[8'h41] = 8'h08;
    for (int k = 2; k <= TX_LEN; k++) begin
      MEM.mem[8'h40 + k] = 8'(k * 5 + 1);
    end
    o = 0;
    af_e = 0;
    fu_e = 0;
    for (int k = 0; k < (h0[HDR_FCS] ? 8 : 10); k++) begin
      e.push_back(MEM.mem[8'h40 + o]);
      af_e += (o == TX_SIG);
      fu_e += (o == TX_LEN);
      o = (o == TX_LEN) ? 0 : o + 1;
    end
    if (h0[HDR_FCS] == FCS_16) begin
      c = crc16(e[2:$]);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    txq.delete();
    af_n = 0;
    full_n = 0;
    done_n = 0;
    @(posedge i_clock);
    i_tx_start <= 1'b1;
    @(posedge i_clock);
    i_tx_start <= 1'b0;
    n = 0;
    while (done_n == 0 && n < 500) begin
      @(negedge i_clock);
      n++;
    end
    if (done_n == 0) fail_wait();
    check(txq.size(), e.size());
    foreach (e[i]) check(txq[i], e[i]);
    check(af_n, af_e);
    check(full_n, fu_e);
    reg_io(1'b0, A_HDR_LO, 8'h00);
    check(o_reg_rdata, h0 & HDR_MASK);
    reg_io(1'b0, A_HDR_HI, 8'h00);
    check(o_reg_rdata, 8'h08);
    check(done_n, 1);
  endtask

  // main sequence
  initial begin
    err_total = 0;
    checked = 0;
    {i_reg_wr, i_reg_rd, i_rx_sfd, i_rx_valid, i_tx_start} = '0;
    {i_tx_ready, i_slow, i_rx_mode, i_tx_mode} = '0;
    {i_reg_addr, i_reg_wdata, i_rx_data} = '0;
    i_rst = 1'b1;
    rows = '{'{A_SFD_LO, 8'ha5, 8'ha5}, '{A_SFD_HI, 8'h3c, 8'h3c},
             '{A_HDR_LO, 8'hff, RST_BYTE}, '{A_HDR_HI, 8'hff, RST_BYTE},
             '{A_RX_SIG, 8'(RX_SIG), 8'(RX_SIG)},
             '{A_RX_LEN, 8'(RX_LEN), 8'(RX_LEN)},
             '{A_TX_SIG, 8'(TX_SIG), 8'(TX_SIG)},
             '{9'h13f, 8'h77, 8'h00}};
    repeat (4) @(posedge i_clock);
    i_rst     <= 1'b0;
    i_rx_mode <= 1'b1;
    i_tx_mode <= 1'b1;
    // offsets above 2 and a ring that leaves room past its end
    foreach (rows[i]) begin
      reg_io(1'b0, rows[i].addr, 8'h00);
      check(o_reg_rdata, RST_BYTE);
      reg_io(1'b1, rows[i].addr, rows[i].wdata);
      reg_io(1'b0, rows[i].addr, 8'h00);
      check(o_reg_rdata, rows[i].exp);
    end
    check(o_sfd_word, 16'h3ca5);
    // slow memory fills the fifo so the stream is refused for a while
    i_slow <= 1'b1;
    rx_frame(8'hf8, 8'h12, 1'b0);
    check(stalls != 0, 1'b1);
    i_slow <= 1'b0;
    rx_frame(8'h10, 8'h0c, 1'b1);
    rx_frame(8'h09, 8'h0c, 1'b0);
    tx_run(8'h10);
    tx_run(8'h80);
    // a start with transmit mode off must not touch the ring
    @(posedge i_clock);
    i_tx_mode  <= 1'b0;
    i_tx_start <= 1'b1;
    @(posedge i_clock);
    i_tx_start <= 1'b0;
    repeat (6) begin
      @(negedge i_clock);
      check({o_mem.en, o_tx_valid}, 2'b00);
    end
    // a delimiter with receive mode off opens no frame
    @(posedge i_clock);
    i_rx_mode <= 1'b0;
    i_rx_sfd  <= 1'b1;
    @(posedge i_clock);
    i_rx_sfd  <= 1'b0;
    rx_byte(8'h55);
    i_rx_valid <= 1'b0;
    repeat (6) begin
      @(negedge i_clock);
      check(o_mem.en, 1'b0);
    end
    // reset in mid-run clears the delimiter word and read data
    @(posedge i_clock);
    i_rst <= 1'b1;
    @(posedge i_clock);
    i_rst <= 1'b0;
    #1;
    check(o_sfd_word, 16'h0000);
    check(o_reg_rdata, RST_BYTE);
    @(posedge i_clock);
    #1;
    check(o_mem.en, 1'b0);
    check(o_sfd_word, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
